// >>> rtl/hec_defines.vh
`ifndef HEC_DEFINES_VH
`define HEC_DEFINES_VH

// Clock rate in kHz (25 MHz)
`define HEC_CLK_KHZ 25000
// Elementary time unit choices in microseconds
`define HEC_TE_US_0 800
`define HEC_TE_US_1 400
`define HEC_TE_US_2 200
`define HEC_TE_US_3 100
// Auto-shutoff time-out in seconds
`define HEC_SHUTOFF_S 25
// Line format codes
`define HEC_FMT_PWM 2'h0
`define HEC_FMT_MAN 2'h1
`define HEC_FMT_VARIABLE_PULSE_WIDTH_FORMAT 2'h2
// Code word layout
`define HEC_HOP_W 32
`define HEC_SER_W 28
`define HEC_FUNC_W 4
`define HEC_STAT_W 2
`define HEC_WORD_W 66
// Counter
`define HEC_CNT_W 16
`define HEC_OVF_RST 2'h3
// Preamble chip toggles (high plus low chips sent, less one)
`define HEC_PRE_LEN 6'h17
// Header gap in elementary time units
`define HEC_HDR_TE 4'hA
// LED flash length in elementary time units
`define HEC_LED_TE 8'h40
// FIFO depth
`define HEC_FIFO_DEPTH 16

`endif

// >>> rtl/hec_fifo.v
`timescale 1ns/1ns
// Small synchronous FIFO with honest full and empty
module hec_fifo #(
	parameter WIDTH = 66,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire mclk,
	input wire rst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word storage
	reg [AW-1:0] wr_q; // Write pointer
	reg [AW-1:0] rd_q; // Read pointer
	reg [AW:0] cnt_q; // Words held
	wire push;
	wire pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage write, no reset needed for data
	always @(posedge mclk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always @(posedge mclk) begin
		if (rst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// >>> rtl/hec_encoder.v
`timescale 1ns/1ns
`include "hec_defines.vh"
// Encoder control: activation, counter, status and serialiser
module hec_encoder #(
	parameter SHUTOFF_CYC = `HEC_SHUTOFF_S * `HEC_CLK_KHZ * 1000,
	parameter SHARED_RF_ENABLE_OUTPUT = 1
) (
	input wire mclk,
	input wire rst,
	input wire [3:0] button_inputs,
	input wire [1:0] te_sel,
	input wire [1:0] format_sel,
	input wire shutoff_en,
	input wire rf_enable_cfg,
	input wire [1:0] ovf_use,
	input wire low_supply,
	input wire [`HEC_SER_W-1:0] serial_number,
	input wire [`HEC_HOP_W-1:0] hop_code,
	input wire hop_valid,
	output reg hop_req,
	output reg [`HEC_CNT_W-1:0] sync_count,
	output reg [1:0] ovf_bits,
	output reg data_out,
	output reg rf_enable_output,
	output reg led_out,
	output reg shutoff_active
);
	// Cycles per elementary time unit, rounded down to whole cycles
	localparam [15:0] TE_CYC0 = `HEC_TE_US_0 * `HEC_CLK_KHZ / 1000;
	localparam [15:0] TE_CYC1 = `HEC_TE_US_1 * `HEC_CLK_KHZ / 1000;
	localparam [15:0] TE_CYC2 = `HEC_TE_US_2 * `HEC_CLK_KHZ / 1000;
	localparam [15:0] TE_CYC3 = `HEC_TE_US_3 * `HEC_CLK_KHZ / 1000;
	localparam [31:0] SHUT_CYC = SHUTOFF_CYC;
	// Controller states
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_HOP = 3'h1;
	localparam [2:0] ST_PUSH = 3'h2;
	localparam [2:0] ST_HELD = 3'h3;
	// Serialiser states
	localparam [2:0] TX_IDLE = 3'h0;
	localparam [2:0] TX_PRE = 3'h1;
	localparam [2:0] TX_HDR = 3'h2;
	localparam [2:0] TX_BIT = 3'h3;
	localparam [2:0] TX_GUARD = 3'h4;

	reg [2:0] st_q; // Activation controller state
	reg [3:0] func_q; // Latched function code
	reg [31:0] hold_q; // Continuous press timer
	reg [65:0] word_q; // Word waiting for FIFO
	reg [2:0] tx_q; // Serialiser state
	reg [65:0] sh_q; // Word being shifted
	reg [6:0] bit_q; // Bits left
	reg [5:0] pre_q; // Preamble chips left
	reg [1:0] ph_q; // Chip phase within a bit
	reg [15:0] te_q; // Elementary unit timer
	reg [3:0] hdr_q; // Header unit counter
	reg [7:0] led_q; // LED flash units left
	reg [1:0] fmt_q; // Format latched per word
	reg [15:0] te_len; // Selected unit length
	wire [3:0] btn_eff; // Buttons as seen by logic
	wire any_btn;
	wire fifo_in_ready;
	wire [65:0] fifo_out;
	wire fifo_out_valid;
	reg fifo_pop;
	wire te_tick;
	wire [`HEC_CNT_W-1:0] cnt_next;

	// RF enable on shared pin masks the top button input
	assign btn_eff = (SHARED_RF_ENABLE_OUTPUT != 0 && rf_enable_cfg) ?
		{1'b0, button_inputs[2:0]} : button_inputs;
	assign any_btn = |btn_eff;
	assign cnt_next = sync_count + 1'b1;
	assign te_tick = (te_q == te_len - 1'b1);

	// Unit length selection
	always @* begin
		case (te_sel)
		2'h0: te_len = TE_CYC0;
		2'h1: te_len = TE_CYC1;
		2'h2: te_len = TE_CYC2;
		default: te_len = TE_CYC3;
		endcase
	end

	// Activation controller: one counter step per press
	always @(posedge mclk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			func_q <= 4'h0;
			hop_req <= 1'b0;
			sync_count <= {`HEC_CNT_W{1'b0}};
			ovf_bits <= `HEC_OVF_RST;
			word_q <= 66'h0;
		end else begin
			case (st_q)
			ST_IDLE: begin
				if (any_btn && !shutoff_active) begin
					func_q <= btn_eff;
					sync_count <= cnt_next;
					// Wrap through zero clears the lowest set overflow bit that ovf_use enables
					if (cnt_next == {`HEC_CNT_W{1'b0}}) begin
						if (ovf_bits[0] && ovf_use[0]) begin
							ovf_bits[0] <= 1'b0;
						end else if (ovf_bits[1] && ovf_use[1]) begin
							ovf_bits[1] <= 1'b0;
						end
					end
					hop_req <= 1'b1;
					st_q <= ST_HOP;
				end
			end
			ST_HOP: begin
				// Cipher engine lives outside; wait for its result
				if (hop_valid) begin
					hop_req <= 1'b0;
					// Word is 66 bits, so only the first overflow bit fits in the status pair
					word_q <= {ovf_bits[0], low_supply, func_q, serial_number,
						hop_code};
					st_q <= ST_PUSH;
				end
			end
			ST_PUSH: begin
				// Stall until FIFO has room
				if (fifo_in_ready) begin
					st_q <= ST_HELD;
				end
			end
			ST_HELD: begin
				// Repeat word while held, until shutoff
				if (!any_btn) begin
					st_q <= ST_IDLE;
				end else if (!shutoff_active && fifo_in_ready && !fifo_out_valid
					&& tx_q == TX_IDLE) begin
					st_q <= ST_PUSH;
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Continuous press timer for auto-shutoff
	always @(posedge mclk) begin
		if (rst) begin
			hold_q <= 32'h0;
			shutoff_active <= 1'b0;
		end else if (!any_btn) begin
			hold_q <= 32'h0;
			shutoff_active <= 1'b0;
		end else if (shutoff_en) begin
			if (hold_q >= SHUT_CYC - 1) begin
				shutoff_active <= 1'b1;
			end else begin
				hold_q <= hold_q + 1'b1;
			end
		end
	end

	hec_fifo #(
		.WIDTH(`HEC_WORD_W),
		.DEPTH(`HEC_FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_data(word_q),
		.in_valid(st_q == ST_PUSH),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop)
	);

	// Pop when serialiser is free and a word is waiting
	always @* begin
		fifo_pop = (tx_q == TX_IDLE) && fifo_out_valid;
	end

	// Serialiser: preamble, header gap, then LSB-first bits
	always @(posedge mclk) begin
		if (rst) begin
			tx_q <= TX_IDLE;
			sh_q <= 66'h0;
			bit_q <= 7'h0;
			pre_q <= 6'h0;
			ph_q <= 2'h0;
			te_q <= 16'h0;
			hdr_q <= 4'h0;
			fmt_q <= `HEC_FMT_PWM;
			data_out <= 1'b0;
			rf_enable_output <= 1'b0;
		end else begin
			te_q <= te_tick ? 16'h0 : te_q + 1'b1;
			case (tx_q)
			TX_IDLE: begin
				te_q <= 16'h0;
				data_out <= 1'b0;
				rf_enable_output <= 1'b0;
				if (fifo_out_valid) begin
					sh_q <= fifo_out;
					fmt_q <= format_sel;
					pre_q <= `HEC_PRE_LEN;
					bit_q <= 7'd66;
					ph_q <= 2'h0;
					data_out <= 1'b1;
					rf_enable_output <= rf_enable_cfg;
					tx_q <= TX_PRE;
				end
			end
			TX_PRE: begin
				// Alternate one unit high, one unit low
				if (te_tick) begin
					if (pre_q == 6'h0) begin
						data_out <= 1'b0;
						hdr_q <= 4'h0;
						tx_q <= TX_HDR;
					end else begin
						pre_q <= pre_q - 1'b1;
						data_out <= ~data_out;
					end
				end
			end
			TX_HDR: begin
				if (te_tick) begin
					if (hdr_q == `HEC_HDR_TE - 1'b1) begin
						tx_q <= TX_BIT;
						ph_q <= 2'h0;
						// Cleared so the guard lasts exactly one unit
						hdr_q <= 4'h0;
						data_out <= (fmt_q == `HEC_FMT_MAN) ? ~sh_q[0] : 1'b1;
					end else begin
						hdr_q <= hdr_q + 1'b1;
					end
				end
			end
			TX_BIT: begin
				if (te_tick) begin
					if (fmt_q == `HEC_FMT_MAN) begin
						// Manchester: two units, mid-bit transition
						if (ph_q == 2'h0) begin
							data_out <= sh_q[0];
							ph_q <= 2'h1;
						end else begin
							sh_q <= {1'b0, sh_q[65:1]};
							bit_q <= bit_q - 1'b1;
							ph_q <= 2'h0;
							data_out <= ~sh_q[1];
							if (bit_q == 7'h1) begin
								tx_q <= TX_GUARD;
								data_out <= 1'b0;
							end
						end
					end else begin
						// PWM: high unit, data unit, low unit; '1' is short high
						ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 1'b1;
						if (ph_q == 2'h0) begin
							data_out <= ~sh_q[0];
						end else if (ph_q == 2'h1) begin
							data_out <= (fmt_q == `HEC_FMT_VARIABLE_PULSE_WIDTH_FORMAT) ? sh_q[0] : 1'b0;
						end else begin
							sh_q <= {1'b0, sh_q[65:1]};
							bit_q <= bit_q - 1'b1;
							data_out <= 1'b1;
							if (bit_q == 7'h1) begin
								tx_q <= TX_GUARD;
								data_out <= 1'b0;
							end
						end
					end
				end
			end
			TX_GUARD: begin
				// Guard time before the next word
				data_out <= 1'b0;
				if (te_tick) begin
					hdr_q <= hdr_q + 1'b1;
					if (hdr_q == 4'h0) begin
						rf_enable_output <= 1'b0;
						tx_q <= TX_IDLE;
					end
				end
			end
			default: tx_q <= TX_IDLE;
			endcase
		end
	end

	// Single LED flash on low battery at press start
	always @(posedge mclk) begin
		if (rst) begin
			led_q <= 8'h0;
			led_out <= 1'b0;
		end else if (st_q == ST_IDLE && any_btn && !shutoff_active && low_supply) begin
			led_q <= `HEC_LED_TE;
			led_out <= 1'b1;
		end else if (led_q != 8'h0) begin
			if (te_tick) begin
				led_q <= led_q - 1'b1;
			end
			led_out <= 1'b1;
		end else begin
			led_out <= 1'b0;
		end
	end
endmodule

// >>> dv/hec_encoder_chk.sv
`timescale 1ns/1ns
// Port-level watcher for the encoder control block
module hec_encoder_chk (
	input wire mclk,
	input wire rst,
	input wire [3:0] button_inputs,
	input wire shutoff_en,
	input wire rf_enable_cfg,
	input wire low_supply,
	input wire hop_valid,
	input wire hop_req,
	input wire [15:0] sync_count,
	input wire [1:0] ovf_bits,
	input wire data_out,
	input wire rf_enable_output,
	input wire led_out,
	input wire shutoff_active
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Past values straddling a reset are ignored, except in chk_shut_en and chk_led_low
	chk_hop_hold: assert property (hop_req && !hop_valid |=> hop_req)
		else $error("hop request dropped early");
	chk_hop_drop: assert property (hop_req && hop_valid |=> !hop_req)
		else $error("hop request kept after answer");
	chk_cnt_step: assert property (!$past(rst) && $rose(hop_req) |->
		sync_count == 16'($past(sync_count) + 16'h1))
		else $error("counter did not step by one");
	chk_cnt_still: assert property (!$past(rst) && !$rose(hop_req) |-> $stable(sync_count))
		else $error("counter moved without activation");
	chk_ovf_wrap: assert property (!$past(rst) && !$stable(ovf_bits) |-> sync_count == 16'h0)
		else $error("overflow bits moved off a wrap");
	chk_ovf_clear: assert property (!$past(rst) |-> (ovf_bits & ~$past(ovf_bits)) == 2'h0)
		else $error("overflow bit was set again");
	chk_shut_rel: assert property (button_inputs == 4'h0 |-> ##[1:2] !shutoff_active)
		else $error("shutoff kept after release");
	chk_shut_en: assert property ($rose(shutoff_active) |-> $past(shutoff_en))
		else $error("shutoff while disabled");
	chk_rf_enable_output_cfg: assert property (rf_enable_output |-> rf_enable_cfg)
		else $error("rf enable without config");
	chk_led_low: assert property ($rose(led_out) |-> $past(low_supply))
		else $error("led flash without low supply");
	// Main scenarios reached
	cov_act: cover property ($rose(hop_req));
	cov_word: cover property ($rose(data_out));
	cov_shut: cover property ($rose(shutoff_active));
endmodule
bind hec_encoder hec_encoder_chk i_hec_encoder_chk (.mclk(mclk), .rst(rst),
	.button_inputs(button_inputs), .shutoff_en(shutoff_en), .rf_enable_cfg(rf_enable_cfg),
	.low_supply(low_supply), .hop_valid(hop_valid), .hop_req(hop_req),
	.sync_count(sync_count), .ovf_bits(ovf_bits), .data_out(data_out),
	.rf_enable_output(rf_enable_output), .led_out(led_out), .shutoff_active(shutoff_active));

// >>> dv/hec_cipher_model.sv
`timescale 1ns/1ns
// Stand-in for the external cipher answering each hop request
module hec_cipher_model (
	input wire mclk,
	input wire rst,
	input wire hop_req,
	input wire slow,
	output logic [31:0] hop_code = 32'h0,
	output logic hop_valid = 1'b0
);
	int wait_q = 0; // Cycles spent on this request
	// Answer quickly or slowly; code word never holds stale data
	always @(posedge mclk) begin
		if (rst || !hop_req || hop_valid) begin
			wait_q <= 0;
			hop_valid <= 1'b0;
			hop_code <= ~hop_code;
		end else begin
			wait_q <= wait_q + 1;
			if (wait_q == (slow ? 40 : 2)) begin
				hop_valid <= 1'b1;
				hop_code <= $urandom;
			end else begin
				hop_code <= ~hop_code;
			end
		end
	end
endmodule

// >>> dv/tb_hec_encoder.sv
`timescale 1ns/1ns
module tb_hec_encoder;
	logic mclk = 0, rst = 1, shutoff_en = 0, rf_enable_cfg = 0, low_supply = 0, slow = 0;
	logic [3:0] button_inputs = 4'h0; // Button levels
	logic [1:0] te_sel = 2'h3, format_sel = 2'h0, ovf_use = 2'h3;
	logic [27:0] serial_number = 28'h0;
	wire [31:0] hop_code;
	wire hop_valid, hop_req, data_out, rf_enable_output, led_out, shutoff_active;
	wire [15:0] sync_count;
	wire [1:0] ovf_bits;
	int err_count = 0, checks_done = 0, cyc = 0, n;
	logic [3:0] b; // Button pattern under test
	localparam int TE_CYC = 100 * 25; // Fastest unit at 25 MHz
	always #20 mclk = ~mclk;
	hec_encoder #(.SHUTOFF_CYC(1000)) i_hec_encoder (.mclk(mclk), .rst(rst),
		.button_inputs(button_inputs), .te_sel(te_sel), .format_sel(format_sel),
		.shutoff_en(shutoff_en), .rf_enable_cfg(rf_enable_cfg), .ovf_use(ovf_use),
		.low_supply(low_supply), .serial_number(serial_number), .hop_code(hop_code),
		.hop_valid(hop_valid), .hop_req(hop_req), .sync_count(sync_count),
		.ovf_bits(ovf_bits), .data_out(data_out), .rf_enable_output(rf_enable_output),
		.led_out(led_out), .shutoff_active(shutoff_active));
	hec_cipher_model i_hec_cipher_model (.mclk(mclk), .rst(rst), .hop_req(hop_req),
		.slow(slow), .hop_code(hop_code), .hop_valid(hop_valid));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// Six-cycle reset with buttons up
	task automatic do_reset;
		@(posedge mclk) rst <= 1'b1;
		button_inputs <= 4'h0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
	endtask
	// Apply a pattern, then look once the design took it
	task automatic press(input logic [3:0] p);
		@(posedge mclk) button_inputs <= p;
		@(posedge mclk);
		#1;
	endtask
	// Hang guard, generous against roughly 4.5k cycles of tests
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 40000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		void'($urandom(32'h1f92));
		do_reset;
		#1;
		chk("ovf_bits", ovf_bits, 2'h3);
		chk("sync_count", sync_count, 16'h0);
		// Corner patterns then random ones, every line format in turn
		for (int i = 0; i < 6; i++) begin
			b = (i == 0) ? 4'hF : (i == 1) ? 4'h1 : 4'($urandom_range(1, 15));
			do_reset;
			format_sel <= 2'(i % 3);
			serial_number <= 28'($urandom);
			press(b);
			chk("hop_req", hop_req, 1'b1);
			chk("sync_count", sync_count, 16'h1);
		end
		// Shared pin: button three masked once rf enable is on
		do_reset;
		rf_enable_cfg <= 1'b1;
		low_supply <= 1'b1;
		press(4'h8);
		repeat (4) @(posedge mclk);
		#1;
		chk("hop_req_masked", hop_req, 1'b0);
		press(4'h9);
		chk("hop_req", hop_req, 1'b1);
		n = 0;
		while (data_out !== 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("data_out", data_out, 1'b1);
		chk("rf_enable_output", rf_enable_output, 1'b1);
		chk("led_out", led_out, 1'b1);
		n = 0;
		while (data_out === 1'b1 && n < 3000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("unit_len", n, TE_CYC);
		// Long press with a slow cipher, then release and press again
		do_reset;
		shutoff_en <= 1'b1;
		rf_enable_cfg <= 1'b0;
		low_supply <= 1'b0;
		slow <= 1'b1;
		press(4'h4);
		n = 0;
		while (shutoff_active !== 1'b1 && n < 1500) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("shutoff_time", (n >= 990 && n <= 1010), 1'b1);
		@(posedge mclk) button_inputs <= 4'h0;
		repeat (3) @(posedge mclk);
		#1;
		chk("shutoff_release", shutoff_active, 1'b0);
		press(4'h4);
		repeat (900) @(posedge mclk);
		#1;
		chk("shutoff_restart", shutoff_active, 1'b0);
		complete_run;
	end
endmodule
